// *** src/ac97_codec_reg_readback.sv ***
// Codec register read-back and slot request registers behind an APB slave
// ============================================================
// Operation
// - Address valid flag set on response, cleared after read
// - Data valid flag set on response, cleared after read
// - Pending flag high while codec read outstanding
// - Returned 7-bit index into bits 22:16
// - Returned 16-bit value into bits 15:0
// - Unused register bits always read zero
// - Slot 1 bits 11:2 to request bits 9:0
// - Slot 12 request bit 0, slot 4 bit 8
// - Address and data arrivals raise separate interrupts
`timescale 1ns/1ps

module ac97_codec_reg_readback (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ac_bit_clk,
   input wire logic ac_sync,
   input wire logic ac_sdata_in,
   output logic irq
);
   import ac97_rb_pkg::*;
   `include "ac97_rb_map.svh"

   rb_st_t r;
   rb_st_t n;
   frame_t frame;
   logic frame_done;
   logic setup_rd;
   logic acc;
   logic acc_wr;
   logic acc_rd;
   logic ev_addr;
   logic ev_data;
   logic [1:0] irq_set;
   logic [1:0] irq_wclr;
   logic [1:0] irq_rclr;
   logic sel_cmd;
   logic sel_resp;
   logic sel_sts;
   logic sel_msk;
   logic cmd_read;
   logic cmd_dir_wr;
   logic [6:0] cmd_index_wr;
   logic [1:0] wr_irq_bits;
   logic tag_ready;
   logic tag_addr;
   logic tag_data;
   logic frame_ok;
   logic [6:0] frame_index;
   logic [15:0] frame_value;
   logic [9:0] frame_requests;

   // ============================================================
   // Link receiver
   ac97_frame_rx u_rx (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .ac_bit_clk(ac_bit_clk),
      .ac_sync(ac_sync),
      .ac_sdata_in(ac_sdata_in),
      .frame(frame),
      .frame_done(frame_done)
   );

   // ============================================================
   // Register decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `OFS_CODEC_COMMAND) || hit(a, `OFS_CODEC_READ_RESPONSE) ||
               hit(a, `OFS_CODEC_SLOT_REQUESTS) || hit(a, `OFS_IRQ_STATUS) ||
               hit(a, `OFS_IRQ_MASK);
   endfunction

   // ============================================================
   // Register words
   function automatic logic [31:0] cmd_word(input rb_st_t s);
      logic [31:0] w;
      w = `RESET_WORD;
      w[`CMD_DIRECTION_BIT] = s.cmd_direction;
      w[`CMD_INDEX_HI:`CMD_INDEX_LO] = s.cmd_index;
      cmd_word = w;
   endfunction

   function automatic logic [31:0] resp_word(input rb_st_t s);
      logic [31:0] w;
      w = `RESET_WORD;
      w[`RESP_ADDR_VALID_BIT] = s.addr_valid;
      w[`RESP_DATA_VALID_BIT] = s.data_valid;
      w[`RESP_PENDING_BIT] = s.pending;
      w[`RESP_INDEX_HI:`RESP_INDEX_LO] = s.resp_index;
      w[`RESP_VALUE_HI:`RESP_VALUE_LO] = s.resp_value;
      resp_word = w;
   endfunction

   function automatic logic [31:0] req_word(input rb_st_t s);
      logic [31:0] w;
      w = `RESET_WORD;
      w[`REQ_HI:0] = s.slot_req;
      req_word = w;
   endfunction

   function automatic logic [31:0] irq_word(input logic [1:0] v);
      logic [31:0] w;
      w = `RESET_WORD;
      w[`IRQ_DATA_BIT:`IRQ_ADDR_BIT] = v;
      irq_word = w;
   endfunction

   function automatic logic irq_line(input logic [1:0] sts, input logic [1:0] msk);
      irq_line = |(sts & msk);
   endfunction

   function automatic logic [31:0] read_word(input rb_st_t s, input logic [7:0] a);
      logic [31:0] w;
      w = `RESET_WORD;
      case (a)
         `OFS_CODEC_COMMAND: begin
            w = cmd_word(s);
         end
         `OFS_CODEC_READ_RESPONSE: begin
            w = resp_word(s);
         end
         `OFS_CODEC_SLOT_REQUESTS: begin
            w = req_word(s);
         end
         `OFS_IRQ_STATUS: begin
            w = irq_word(s.irq_status);
         end
         `OFS_IRQ_MASK: begin
            w = irq_word(s.irq_mask);
         end
         default: begin
            w = `RESET_WORD;
         end
      endcase
      read_word = w;
   endfunction

   // ============================================================
   // Incoming slot fields
   function automatic logic [6:0] slot_index(input logic [19:0] s);
      slot_index = s[`SLOT1_INDEX_HI:`SLOT1_INDEX_LO];
   endfunction

   function automatic logic [15:0] slot_value(input logic [19:0] s);
      slot_value = s[`SLOT2_VALUE_HI:`SLOT2_VALUE_LO];
   endfunction

   function automatic logic [9:0] slot_requests(input logic [19:0] s);
      slot_requests = s[`SLOT1_REQ_HI:`SLOT1_REQ_LO];
   endfunction

   // ============================================================
   // Bus phases
   assign setup_rd = psel && !penable;
   assign acc = psel && penable;
   assign acc_wr = acc && pwrite && mapped(paddr);
   assign acc_rd = acc && !pwrite && mapped(paddr);

   // ============================================================
   // Register select
   assign sel_cmd = hit(paddr, `OFS_CODEC_COMMAND);
   assign sel_resp = hit(paddr, `OFS_CODEC_READ_RESPONSE);
   assign sel_sts = hit(paddr, `OFS_IRQ_STATUS);
   assign sel_msk = hit(paddr, `OFS_IRQ_MASK);

   // ============================================================
   // Write data fields
   assign cmd_dir_wr = pwdata[`CMD_DIRECTION_BIT];
   assign cmd_index_wr = pwdata[`CMD_INDEX_HI:`CMD_INDEX_LO];
   assign wr_irq_bits = pwdata[`IRQ_DATA_BIT:`IRQ_ADDR_BIT];
   assign cmd_read = acc_wr && sel_cmd && cmd_dir_wr;

   // ============================================================
   // Frame events
   assign tag_ready = frame.tag[`TAG_READY_BIT];
   assign tag_addr = frame.tag[`TAG_SLOT1_BIT];
   assign tag_data = frame.tag[`TAG_SLOT2_BIT];
   assign frame_ok = frame_done && tag_ready;
   assign ev_addr = frame_ok && tag_addr;
   assign ev_data = frame_ok && tag_data;
   assign frame_index = slot_index(frame.slot1);
   assign frame_value = slot_value(frame.slot2);
   assign frame_requests = slot_requests(frame.slot1);

   // ============================================================
   // Interrupt set and clear terms
   always_comb begin
      irq_set = 2'h0;
      irq_set[`IRQ_ADDR_BIT] = ev_addr;
      irq_set[`IRQ_DATA_BIT] = ev_data;

      // ============================================================
      // Write-one and read clears
      irq_wclr = 2'h0;
      if (acc_wr && sel_sts) begin
         irq_wclr = wr_irq_bits;
      end
      // Only the bits that the read returned are cleared
      irq_rclr = 2'h0;
      if (acc_rd && sel_sts) begin
         irq_rclr = r.prdata[`IRQ_DATA_BIT:`IRQ_ADDR_BIT];
      end
   end

   // ============================================================
   // Next state
   always_comb begin
      n = r;
      n.slverr = 1'b0;

      // ============================================================
      // Read data and error prepared in the setup cycle
      if (setup_rd) begin
         n.prdata = read_word(r, paddr);
         n.slverr = !mapped(paddr);
      end

      // ============================================================
      // Command and mask writes
      if (acc_wr && sel_cmd) begin
         n.cmd_direction = cmd_dir_wr;
         n.cmd_index = cmd_index_wr;
      end
      if (acc_wr && sel_msk) begin
         n.irq_mask = wr_irq_bits;
      end
      // Writes to the read-back registers are ignored

      // ============================================================
      // Response read ends the read processing for returned flags
      if (acc_rd && sel_resp) begin
         if (r.prdata[`RESP_ADDR_VALID_BIT]) begin
            n.addr_valid = 1'b0;
         end
         if (r.prdata[`RESP_DATA_VALID_BIT]) begin
            n.data_valid = 1'b0;
         end
      end

      // ============================================================
      // Captured frame, set wins over the read clear
      if (frame_ok) begin
         n.slot_req = frame_requests;
      end
      if (ev_addr) begin
         n.resp_index = frame_index;
         n.addr_valid = 1'b1;
      end
      if (ev_data) begin
         n.resp_value = frame_value;
         n.data_valid = 1'b1;
         n.pending = 1'b0;
      end
      // A new read command wins over the answer to the last one
      if (cmd_read) begin
         n.pending = 1'b1;
      end

      n.irq_status = (r.irq_status & ~(irq_wclr | irq_rclr)) | irq_set;
   end

   // ============================================================
   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ============================================================
   // Outputs
   assign prdata = r.prdata;

   // ============================================================
   // Interrupt line
   assign irq = irq_line(r.irq_status, r.irq_mask);

   // ============================================================
   // Handshake
   always_comb begin
      pready = acc;
      pslverr = 1'b0;
      if (acc) begin
         pslverr = r.slverr;
      end
   end

endmodule

// *** src/ac97_rb_map.svh ***
// Register map, field positions and reset values of the codec read-back block
`ifndef AC97_RB_MAP_SVH
`define AC97_RB_MAP_SVH

// ============================================================
// Register offsets
`define OFS_CODEC_COMMAND 8'h04
`define OFS_CODEC_READ_RESPONSE 8'h08
`define OFS_CODEC_SLOT_REQUESTS 8'h0c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24

// ============================================================
// Read response fields
`define RESP_ADDR_VALID_BIT 31
`define RESP_DATA_VALID_BIT 30
`define RESP_PENDING_BIT 29
`define RESP_INDEX_HI 22
`define RESP_INDEX_LO 16
`define RESP_VALUE_HI 15
`define RESP_VALUE_LO 0

// ============================================================
// Command fields
`define CMD_DIRECTION_BIT 23
`define CMD_INDEX_HI 22
`define CMD_INDEX_LO 16

// ============================================================
// Slot requests and incoming slot 1 and slot 2 layout
`define REQ_HI 9
`define SLOT1_REQ_HI 11
`define SLOT1_REQ_LO 2
`define SLOT1_INDEX_HI 18
`define SLOT1_INDEX_LO 12
`define SLOT2_VALUE_HI 19
`define SLOT2_VALUE_LO 4

// ============================================================
// Incoming tag bits
`define TAG_READY_BIT 15
`define TAG_SLOT1_BIT 14
`define TAG_SLOT2_BIT 13

// ============================================================
// Interrupt bits
`define IRQ_ADDR_BIT 0
`define IRQ_DATA_BIT 1

// ============================================================
// Frame counts and reset values
`define TAG_LAST_BIT 5'd15
`define SLOT_LAST_BIT 5'd19
`define RESET_WORD 32'h0000_0000

`endif

// *** src/ac97_rb_pkg.sv ***
// Types shared by the codec read-back block
package ac97_rb_pkg;

   // ============================================================
   // Slots captured from one incoming frame
   typedef struct packed {
      logic [15:0] tag;
      logic [19:0] slot1;
      logic [19:0] slot2;
   } frame_t;

   typedef enum logic [2:0] {RX_IDLE, RX_TAG, RX_SLOT1, RX_SLOT2, RX_REST} rx_state_t;

   // ============================================================
   // Receiver state
   typedef struct packed {
      logic bclk_s1;
      logic bclk_s2;
      logic bclk_d;
      logic sync_s1;
      logic sync_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic sync_seen;
      rx_state_t st;
      logic [4:0] cnt;
      logic [19:0] sh;
      logic [15:0] tag;
      logic [19:0] s1;
      frame_t fr;
      logic done;
   } rx_st_t;

   // ============================================================
   // Register block state
   typedef struct packed {
      logic addr_valid;
      logic data_valid;
      logic pending;
      logic cmd_direction;
      logic [6:0] cmd_index;
      logic [6:0] resp_index;
      logic [15:0] resp_value;
      logic [9:0] slot_req;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [31:0] prdata;
      logic slverr;
   } rb_st_t;

endpackage

// *** src/ac97_frame_rx.sv ***
// AC-link input frame receiver, oversampled on the system clock
`timescale 1ns/1ps

module ac97_frame_rx (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ac_bit_clk,
   input wire logic ac_sync,
   input wire logic ac_sdata_in,
   output ac97_rb_pkg::frame_t frame,
   output logic frame_done
);
   import ac97_rb_pkg::*;
   `include "ac97_rb_map.svh"

   rx_st_t r;
   rx_st_t n;

   // ============================================================
   // Next state
   always_comb begin
      n = r;
      n.bclk_s1 = ac_bit_clk;
      n.bclk_s2 = r.bclk_s1;
      n.bclk_d = r.bclk_s2;
      n.sync_s1 = ac_sync;
      n.sync_s2 = r.sync_s1;
      n.sdi_s1 = ac_sdata_in;
      n.sdi_s2 = r.sdi_s1;
      n.done = 1'b0;
      // Falling bit clock edge samples a bit
      if (r.bclk_d && !r.bclk_s2) begin
         n.sync_seen = r.sync_s2;
         n.sh = {r.sh[18:0], r.sdi_s2};
         n.cnt = r.cnt + 5'd1;
         case (r.st)
            RX_IDLE: begin
               n.cnt = 5'd0;
            end
            RX_TAG: begin
               if (r.cnt == `TAG_LAST_BIT) begin
                  n.tag = {r.sh[14:0], r.sdi_s2};
                  n.st = RX_SLOT1;
                  n.cnt = 5'd0;
               end
            end
            RX_SLOT1: begin
               if (r.cnt == `SLOT_LAST_BIT) begin
                  n.s1 = {r.sh[18:0], r.sdi_s2};
                  n.st = RX_SLOT2;
                  n.cnt = 5'd0;
               end
            end
            RX_SLOT2: begin
               if (r.cnt == `SLOT_LAST_BIT) begin
                  n.fr = '{tag: r.tag, slot1: r.s1, slot2: {r.sh[18:0], r.sdi_s2}};
                  n.done = 1'b1;
                  n.st = RX_REST;
                  n.cnt = 5'd0;
               end
            end
            RX_REST: begin
               n.cnt = 5'd0;
            end
            default: begin
               n.st = RX_IDLE;
            end
         endcase
         // Rising sync marks the first tag bit
         if (r.sync_s2 && !r.sync_seen) begin
            n.st = RX_TAG;
            n.cnt = 5'd1;
         end
      end
   end

   // ============================================================
   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign frame = r.fr;
   assign frame_done = r.done;

endmodule

// *** test/ac97_codec_model.sv ***
// Codec side of the link: sends one input frame on demand
`timescale 1ns/1ps
module ac97_codec_model (
   output logic ac_bit_clk,
   output logic ac_sync,
   output logic ac_sdata_in
);
   initial begin
      ac_bit_clk = 1'b0;
      ac_sync = 1'b0;
      ac_sdata_in = 1'b0;
   end
   // ============================================================
   // Frame: tag, slot 1, slot 2 MSB first; clock still between frames
   task automatic frame(input logic [55:0] v);
      for (int i = -2; i < 58; i++) begin
         ac_bit_clk = 1'b1;
         ac_sync = (i >= 0 && i < 16);
         ac_sdata_in = (i >= 0 && i < 56) ? v[55 - i] : ~ac_sdata_in;
         #62.5;
         ac_bit_clk = 1'b0;
         #62.5;
      end
      ac_sdata_in = ~ac_sdata_in;
   endtask
endmodule

// *** test/ac97_rb_checker.sv ***
// Port checks of the codec read-back block
`timescale 1ns/1ps
module ac97_rb_checker (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   logic acc;
   logic rd_acc;
   logic mapped;
   assign acc = psel && penable;
   assign rd_acc = acc && !pwrite;
   assign mapped = paddr inside {8'h04, 8'h08, 8'h0c, 8'h20, 8'h24};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ============================================================
   // Assertions
   a_ready_zero_wait: assert property (pready == acc)
      else $error("pready differs from access phase");
   a_err_in_access: assert property (pslverr |-> acc)
      else $error("pslverr outside access phase");
   a_unmapped_refused: assert property (rd_acc && !mapped |-> pslverr && prdata == 0)
      else $error("unmapped read not refused");
   a_mapped_no_err: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_resp_reserved_zero: assert property (rd_acc && paddr == 8'h08 |-> prdata[28:23] == 0)
      else $error("response reserved bits set");
   a_req_reserved_zero: assert property (rd_acc && paddr == 8'h0c |-> prdata[31:10] == 0)
      else $error("request reserved bits set");
   a_rdata_held: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data changed outside setup");
   a_irq_low_reset: assert property ($rose(nrst) |-> !irq)
      else $error("irq high after reset");
endmodule
bind ac97_codec_reg_readback ac97_rb_checker i_chk (.ref_clk, .nrst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .irq);

// *** test/ac97_codec_reg_readback_test.sv ***
// Self-checking bench of the codec read-back block
`timescale 1ns/1ps
module ac97_codec_reg_readback_test;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, d;
   logic pready, pslverr, ac_bit_clk, ac_sync, ac_sdata_in, irq, err;
   logic [15:0] tag;
   logic [19:0] s1, s2;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int av, dv, pend, idx, val, req, sts, msk;
   always #2.5 ref_clk = ~ref_clk;
   ac97_codec_reg_readback i_dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ac_bit_clk, .ac_sync, .ac_sdata_in, .irq);
   ac97_codec_model i_codec (.ac_bit_clk, .ac_sync, .ac_sdata_in);
   // ============================================================
   // Tasks
   task automatic conclude();
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic rresp();
      rchk("resp", 8'h08, {av[0], dv[0], pend[0], 6'h00, idx[6:0], val[15:0]});
      av = 0;
      dv = 0;
   endtask
   // ============================================================
   // Main sequence
   initial begin
      void'($urandom(32'hfeee9563));
      {av, dv, pend, idx, val, req, sts, msk} = '0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      rchk("resp_reset", 8'h08, 32'h0);
      rchk("req_reset", 8'h0c, 32'h0);
      apb(1'b1, 8'h08, $urandom & 32'he07f_ffff);
      apb(1'b1, 8'h0c, $urandom & 32'h0000_03ff);
      rchk("resp_ro", 8'h08, 32'h0);
      rchk("req_ro", 8'h0c, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped_err", 32'h1, err);
      chk("unmapped_data", 32'h0, rd);
      repeat (24) begin
         msk = $urandom % 4;
         apb(1'b1, 8'h24, msk);
         d = $urandom & 32'h00ff_ffff;
         apb(1'b1, 8'h04, d);
         pend |= d[23];
         rresp();
         tag = $urandom;
         tag[15] = ($urandom % 8) != 0;
         s1 = $urandom;
         s2 = $urandom;
         i_codec.frame({tag, s1, s2});
         repeat (20) @(posedge ref_clk);
         if (tag[15]) begin
            req = s1[11:2];
            if (tag[14]) begin
               idx = s1[18:12];
               av = 1;
               sts |= 1;
            end
            if (tag[13]) begin
               val = s2[19:4];
               dv = 1;
               pend = 0;
               sts |= 2;
            end
         end
         chk("irq", (sts & msk) != 0, irq);
         rchk("req", 8'h0c, req);
         rresp();
         if ($urandom % 2) begin
            rchk("irq_sts", 8'h20, sts);
            sts = 0;
         end else begin
            d = $urandom % 4;
            apb(1'b1, 8'h20, d);
            sts &= ~d;
         end
         @(posedge ref_clk);
         chk("irq_clr", (sts & msk) != 0, irq);
      end
      conclude();
   end
endmodule
